// ---- ddr_phy_misc_efifo_control.sv ----
// Control register bank for the DDR2 PHY clocking, pads and elastic FIFO
`timescale 1ns/100ps
`default_nettype none

module ddr_phy_misc_efifo_control
	import ddr_phy_misc_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// Avalon-MM slave
	input  wire logic [11:0] address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	output logic      [1:0]  response,
	// Controller status
	input  wire logic        selfRefreshActive,
	// PHY controls
	output logic             phyClockEn,
	output logic      [2:0]  cmdAddrPositionAdjust,
	output logic      [3:0]  memclkDutyAdjust,
	output logic             selfRefreshHoldN,
	output logic             padVoltageSelect,
	output logic             gateMarginCheckEn,
	output logic             dataEyeCheckEn,
	output logic      [2:0]  vrefRatioSelect,
	output logic      [2:0]  dataDriveStrength,
	output logic      [2:0]  cmdDriveStrength,
	output logic             efifoReset,
	output logic      [1:0]  readSyncPosition,
	output logic      [1:0]  cmdSyncPosition,
	output logic      [2:0]  cmdBlockSkew,
	output logic      [4:0]  cmdBlockTreeDelay
);

	// ==========================================================
	// Bus handshake
	// ==========================================================
	logic        ack_ff;
	logic        selfRefreshPrev_ff;
	logic [31:0] misc_ff;
	logic [31:0] fifo_ff;
	logic [31:0] tree_ff;

	// Clamp an undefined synchronization position onto the last valid stage
	function automatic logic [1:0] clampSync(input logic [1:0] pos);
		clampSync = (pos > SYNC_POS_MAX) ? SYNC_POS_MAX : pos;
	endfunction

	// Byte-enable merge of a write into a field mask
	function automatic logic [31:0] mergeWrite(input logic [31:0] old, input logic [31:0] mask);
		logic [31:0] lanes;
		lanes = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
		mergeWrite = ((old & ~(lanes & mask)) | (writedata & lanes & mask)) & mask;
	endfunction

	localparam logic [31:0] MISC_MASK = 32'h00fff777;
	localparam logic [31:0] FIFO_MASK = 32'h0000001f;
	localparam logic [31:0] TREE_MASK = 32'h0000071f;

	wire logic busReq    = (read | write) & ~ack_ff;
	// Write lands on the edge at which the master sees waitrequest low
	wire logic wrAccept  = write & ack_ff;
	wire logic hitMisc   = (address == PHY_MISC_CONTROL_TWO_OFS);
	wire logic hitFifo   = (address == ELASTIC_FIFO_CONTROL_OFS);
	wire logic hitTree   = (address == COMMAND_CLOCK_TREE_CONTROL_OFS);
	wire logic hitAny    = hitMisc | hitFifo | hitTree;

	// One wait cycle, then the answer is given with waitrequest low
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			ack_ff <= 1'b0;
		else
			ack_ff <= busReq;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			waitrequest <= 1'b1;
		else
			waitrequest <= ~busReq;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			readdata <= 32'h00000000;
			response <= 2'h0;
		end
		else if (busReq)
		begin
			response <= hitAny ? 2'h0 : 2'h3;
			if (!read || !hitAny)
				readdata <= UNMAPPED_DATA;
			else if (hitMisc)
				readdata <= misc_ff;
			else if (hitFifo)
				readdata <= fifo_ff;
			else
				readdata <= tree_ff;
		end
	end

	// ==========================================================
	// Register storage
	// ==========================================================
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			misc_ff <= 32'h00000000;
			misc_ff[CLOCK_EN_POS] <= CLOCK_EN_RST;
			misc_ff[CMD_POS_ADJ_LSB +: 3] <= CMD_POS_ADJ_RST;
			misc_ff[DUTY_ADJ_LSB +: 4] <= DUTY_ADJ_RST;
			misc_ff[SELF_REFRESH_POS] <= SELF_REFRESH_RST;
			misc_ff[PAD_VOLTAGE_POS] <= PAD_VOLTAGE_RST;
			misc_ff[GATE_CHECK_POS] <= GATE_CHECK_RST;
			misc_ff[EYE_CHECK_POS] <= EYE_CHECK_RST;
			misc_ff[VREF_SEL_LSB +: 3] <= VREF_SEL_RST;
			misc_ff[DATA_DRIVE_LSB +: 3] <= DATA_DRIVE_RST;
			misc_ff[CMD_DRIVE_LSB +: 3] <= CMD_DRIVE_RST;
		end
		else if (wrAccept && hitMisc)
			misc_ff <= mergeWrite(misc_ff, MISC_MASK);
	end

	// FIFO reset bit is never stored, so it always reads back as zero
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fifo_ff <= 32'h00000000;
			fifo_ff[AUTO_RESET_POS] <= AUTO_RESET_RST;
			fifo_ff[READ_SYNC_LSB +: 2] <= READ_SYNC_RST;
			fifo_ff[CMD_SYNC_LSB +: 2] <= CMD_SYNC_RST;
		end
		else if (wrAccept && hitFifo)
			fifo_ff <= mergeWrite(fifo_ff, FIFO_MASK);
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tree_ff <= 32'h00000000;
			tree_ff[CMD_SKEW_LSB +: 3] <= CMD_SKEW_RST;
			tree_ff[CMD_TREE_DELAY_LSB +: 5] <= CMD_TREE_DLY_RST;
		end
		else if (wrAccept && hitTree)
			tree_ff <= mergeWrite(tree_ff, TREE_MASK);
	end

	// ==========================================================
	// Elastic FIFO reset pulse
	// ==========================================================
	wire logic swFifoReset   = wrAccept & hitFifo & byteenable[1] & writedata[FIFO_RESET_POS];
	wire logic srEntry       = selfRefreshActive & ~selfRefreshPrev_ff;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			selfRefreshPrev_ff <= 1'b0;
		else
			selfRefreshPrev_ff <= selfRefreshActive;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			efifoReset <= 1'b0;
		else
			efifoReset <= swFifoReset | (srEntry & fifo_ff[AUTO_RESET_POS]);
	end

	// ==========================================================
	// PHY control outputs
	// ==========================================================
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			phyClockEn            <= CLOCK_EN_RST;
			cmdAddrPositionAdjust <= CMD_POS_ADJ_RST;
			memclkDutyAdjust      <= DUTY_ADJ_RST;
			selfRefreshHoldN      <= SELF_REFRESH_RST;
			padVoltageSelect      <= PAD_VOLTAGE_RST;
			gateMarginCheckEn     <= GATE_CHECK_RST;
			dataEyeCheckEn        <= EYE_CHECK_RST;
			vrefRatioSelect       <= VREF_SEL_RST;
			dataDriveStrength     <= DATA_DRIVE_RST;
			cmdDriveStrength      <= CMD_DRIVE_RST;
			readSyncPosition      <= READ_SYNC_RST;
			cmdSyncPosition       <= CMD_SYNC_RST;
			cmdBlockSkew          <= CMD_SKEW_RST;
			cmdBlockTreeDelay     <= CMD_TREE_DLY_RST;
		end
		else
		begin
			phyClockEn            <= misc_ff[CLOCK_EN_POS];
			cmdAddrPositionAdjust <= misc_ff[CMD_POS_ADJ_LSB +: 3];
			memclkDutyAdjust      <= misc_ff[DUTY_ADJ_LSB +: 4];
			selfRefreshHoldN      <= misc_ff[SELF_REFRESH_POS];
			padVoltageSelect      <= misc_ff[PAD_VOLTAGE_POS];
			gateMarginCheckEn     <= misc_ff[GATE_CHECK_POS];
			dataEyeCheckEn        <= misc_ff[EYE_CHECK_POS];
			vrefRatioSelect       <= misc_ff[VREF_SEL_LSB + 2] ? 3'h4 : misc_ff[VREF_SEL_LSB +: 3];
			dataDriveStrength     <= misc_ff[DATA_DRIVE_LSB +: 3];
			cmdDriveStrength      <= misc_ff[CMD_DRIVE_LSB +: 3];
			readSyncPosition      <= clampSync(fifo_ff[READ_SYNC_LSB +: 2]);
			cmdSyncPosition       <= clampSync(fifo_ff[CMD_SYNC_LSB +: 2]);
			cmdBlockSkew          <= tree_ff[CMD_SKEW_LSB +: 3];
			cmdBlockTreeDelay     <= tree_ff[CMD_TREE_DELAY_LSB +: 5];
		end
	end

	// ==========================================================
	// Assertions
	// ==========================================================
	sequence sFifoResetWrite;
		wrAccept && hitFifo && byteenable[1] && writedata[FIFO_RESET_POS];
	endsequence

	a_fifo_reset_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
		sFifoResetWrite |=> efifoReset)
		else $error("FIFO reset write gave no pulse");
	a_fifo_reset_cause: assert property (@(posedge ref_clk) disable iff (!rst_n)
		efifoReset |-> $past(swFifoReset) || $past(srEntry && fifo_ff[AUTO_RESET_POS]))
		else $error("FIFO reset without cause");
	a_auto_reset_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(selfRefreshActive && !selfRefreshPrev_ff && fifo_ff[AUTO_RESET_POS]) |=> efifoReset)
		else $error("Self-refresh entry did not reset FIFO");
	a_reset_bit_reads0: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(ack_ff && read && hitFifo) |-> !readdata[FIFO_RESET_POS])
		else $error("FIFO reset bit stored");
	a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
		((misc_ff & ~MISC_MASK) == 32'h0) && ((tree_ff & ~TREE_MASK) == 32'h0))
		else $error("Reserved bits set");
	a_sync_clamped: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(fifo_ff[READ_SYNC_LSB +: 2] == 2'h3) |=> (readSyncPosition == 2'h2))
		else $error("Read sync position not clamped");
	a_vref_midpoint: assert property (@(posedge ref_clk) disable iff (!rst_n)
		misc_ff[VREF_SEL_LSB + 2] |=> (vrefRatioSelect == 3'h4))
		else $error("Bias code above 3 not midpoint");
	a_clock_en_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(wrAccept && hitMisc && byteenable[2]) |=> ##1 (phyClockEn == $past(writedata[CLOCK_EN_POS], 2)))
		else $error("Clock enable not applied");
	a_skew_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(wrAccept && hitTree && byteenable[1]) |=> ##1 (cmdBlockSkew == $past(writedata[10:8], 2)))
		else $error("Skew not applied");
	a_answer_one_wait: assert property (@(posedge ref_clk) disable iff (!rst_n)
		busReq |=> !waitrequest ##1 waitrequest)
		else $error("Answer timing wrong");

endmodule

`default_nettype wire

// ---- ddr_phy_misc_pkg.sv ----
// Register map and field layout of the PHY miscellaneous and elastic FIFO control bank
package ddr_phy_misc_pkg;
	localparam logic [11:0] PHY_MISC_CONTROL_TWO_OFS       = 12'h134;
	localparam logic [11:0] ELASTIC_FIFO_CONTROL_OFS       = 12'h138;
	localparam logic [11:0] COMMAND_CLOCK_TREE_CONTROL_OFS = 12'h13c;

	// Field positions of the PHY miscellaneous register
	localparam int CLOCK_EN_POS       = 23;
	localparam int CMD_POS_ADJ_LSB    = 20;
	localparam int DUTY_ADJ_LSB       = 16;
	localparam int SELF_REFRESH_POS   = 15;
	localparam int PAD_VOLTAGE_POS    = 14;
	localparam int GATE_CHECK_POS     = 13;
	localparam int EYE_CHECK_POS      = 12;
	localparam int VREF_SEL_LSB       = 8;
	localparam int DATA_DRIVE_LSB     = 4;
	localparam int CMD_DRIVE_LSB      = 0;

	// Field positions of the elastic FIFO control register
	localparam int FIFO_RESET_POS     = 8;
	localparam int AUTO_RESET_POS     = 4;
	localparam int READ_SYNC_LSB      = 2;
	localparam int CMD_SYNC_LSB       = 0;

	// Field positions of the command clock tree register
	localparam int CMD_SKEW_LSB       = 8;
	localparam int CMD_TREE_DELAY_LSB = 0;

	// Reset values
	localparam logic       CLOCK_EN_RST     = 1'h1;
	localparam logic [2:0] CMD_POS_ADJ_RST  = 3'h7;
	localparam logic [3:0] DUTY_ADJ_RST     = 4'h8;
	localparam logic       SELF_REFRESH_RST = 1'h1;
	localparam logic       PAD_VOLTAGE_RST  = 1'h1;
	localparam logic       GATE_CHECK_RST   = 1'h0;
	localparam logic       EYE_CHECK_RST    = 1'h0;
	localparam logic [2:0] VREF_SEL_RST     = 3'h4;
	localparam logic [2:0] DATA_DRIVE_RST   = 3'h1;
	localparam logic [2:0] CMD_DRIVE_RST    = 3'h7;
	localparam logic       AUTO_RESET_RST   = 1'h0;
	localparam logic [1:0] READ_SYNC_RST    = 2'h0;
	localparam logic [1:0] CMD_SYNC_RST     = 2'h0;
	localparam logic [2:0] CMD_SKEW_RST     = 3'h3;
	localparam logic [4:0] CMD_TREE_DLY_RST = 5'h0;

	// Highest legal synchronization position
	localparam logic [1:0] SYNC_POS_MAX     = 2'h2;
	// Read data returned for unmapped addresses
	localparam logic [31:0] UNMAPPED_DATA   = 32'h00000000;
endpackage

// ---- phy_side_model.sv ----
// Behavioural model of the PHY side: self-refresh status and elastic FIFO reset counter
`timescale 1ns/100ps
`default_nettype none
module phy_side_model
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// From the register bank
	input  wire logic       efifoReset,
	// Bench stimulus
	input  wire logic       srfReq,
	// Status
	output logic            selfRefreshActive,
	output logic      [7:0] fifoResets
);
	logic       srfActive_ff;
	logic [7:0] resetCount_ff;

	// Controller enters self-refresh one cycle after the bench asks
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			srfActive_ff <= 1'b0;
		else
			srfActive_ff <= srfReq;
	end

	// Every high cycle of the reset strobe counts as one FIFO reset
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			resetCount_ff <= 8'h00;
		else if (efifoReset)
			resetCount_ff <= resetCount_ff + 8'h01;
	end

	assign selfRefreshActive = srfActive_ff;
	assign fifoResets        = resetCount_ff;
endmodule
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the PHY control register bank
`timescale 1ns/100ps
`default_nettype none
module tb
	import ddr_phy_misc_pkg::*;
;
	logic ref_clk, rst_n, read, write, srfReq, selfRefreshActive, waitrequest, efifoReset;
	logic phyClockEn, selfRefreshHoldN, padVoltageSelect, gateMarginCheckEn, dataEyeCheckEn;
	logic [11:0] address;
	logic [31:0] writedata, readdata, phyVec;
	logic [3:0]  byteenable, memclkDutyAdjust;
	logic [1:0]  response, readSyncPosition, cmdSyncPosition;
	logic [2:0]  cmdAddrPositionAdjust, vrefRatioSelect, dataDriveStrength, cmdDriveStrength, cmdBlockSkew;
	logic [4:0]  cmdBlockTreeDelay;
	logic [7:0]  fifoResets, n;
	int          n_mismatch, comparisons, cycles;

	ddr_phy_misc_efifo_control i_ddr_phy_misc_efifo_control (.ref_clk(ref_clk), .rst_n(rst_n),
		.address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .response(response),
		.selfRefreshActive(selfRefreshActive), .phyClockEn(phyClockEn),
		.cmdAddrPositionAdjust(cmdAddrPositionAdjust), .memclkDutyAdjust(memclkDutyAdjust),
		.selfRefreshHoldN(selfRefreshHoldN), .padVoltageSelect(padVoltageSelect),
		.gateMarginCheckEn(gateMarginCheckEn), .dataEyeCheckEn(dataEyeCheckEn),
		.vrefRatioSelect(vrefRatioSelect), .dataDriveStrength(dataDriveStrength),
		.cmdDriveStrength(cmdDriveStrength), .efifoReset(efifoReset), .readSyncPosition(readSyncPosition),
		.cmdSyncPosition(cmdSyncPosition), .cmdBlockSkew(cmdBlockSkew), .cmdBlockTreeDelay(cmdBlockTreeDelay));

	phy_side_model i_phy_side_model (.ref_clk(ref_clk), .rst_n(rst_n), .efifoReset(efifoReset),
		.srfReq(srfReq), .selfRefreshActive(selfRefreshActive), .fifoResets(fifoResets));

	assign phyVec = {11'h0, phyClockEn, cmdAddrPositionAdjust, memclkDutyAdjust, selfRefreshHoldN,
		padVoltageSelect, gateMarginCheckEn, dataEyeCheckEn, vrefRatioSelect, dataDriveStrength, cmdDriveStrength};

	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// ==========================================
	// Checking and bus tasks
	task close_out;
		if (n_mismatch == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task cmp(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge ref_clk);
		address <= a;
		writedata <= d;
		byteenable <= be;
		write <= 1'b1;
		do @(posedge ref_clk); while (waitrequest !== 1'b0);
		write <= 1'b0;
	endtask

	task rdchk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] rexp);
		@(posedge ref_clk);
		address <= a;
		read <= 1'b1;
		do @(posedge ref_clk); while (waitrequest !== 1'b0);
		cmp(readdata, exp);
		cmp({30'h0, response}, {30'h0, rexp});
		read <= 1'b0;
	endtask

	task settle;
		repeat (2) @(posedge ref_clk);
	endtask

	// Hang guard
	always @(posedge ref_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			n_mismatch++;
			close_out;
		end
	end

	// ==========================================
	// Test sequence
	initial
	begin
		{address, read, write, writedata, byteenable, srfReq, n_mismatch, comparisons} = '0;
		rst_n = 1'b0;
		repeat (6) @(posedge ref_clk);
		cmp(phyVec, {11'h0, CLOCK_EN_RST, CMD_POS_ADJ_RST, DUTY_ADJ_RST, SELF_REFRESH_RST, PAD_VOLTAGE_RST,
			GATE_CHECK_RST, EYE_CHECK_RST, VREF_SEL_RST, DATA_DRIVE_RST, CMD_DRIVE_RST});
		rst_n <= 1'b1;
		rdchk(12'h134, 32'h00f8c417, 2'h0);
		rdchk(12'h138, 32'h00000000, 2'h0);
		rdchk(12'h13c, 32'h00000300, 2'h0);
		wr(12'h134, 32'hffffffff, 4'hf);
		settle;
		cmp(phyVec, {11'h0, 1'b1, 3'h7, 4'hf, 4'hf, 3'h4, 3'h7, 3'h7});
		rdchk(12'h134, 32'h00fff777, 2'h0);
		wr(12'h134, 32'h00000000, 4'hf);
		settle;
		cmp(phyVec, 32'h0);
		for (int c = 0; c < 8; c++)
		begin
			wr(12'h134, 32'(c) << 8, 4'h2);
			settle;
			cmp({29'h0, vrefRatioSelect}, (c < 4) ? 32'(c) : 32'h4);
		end
		for (int c = 0; c < 4; c++)
		begin
			wr(12'h138, 32'(c * 5), 4'h1);
			settle;
			cmp({28'h0, readSyncPosition, cmdSyncPosition}, (c == 3) ? 32'ha : 32'(c * 5));
		end
		rdchk(12'h138, 32'h0000000f, 2'h0);
		wr(12'h13c, 32'hffffffff, 4'h1);
		rdchk(12'h13c, 32'h0000031f, 2'h0);
		wr(12'h13c, 32'hffffffff, 4'h2);
		rdchk(12'h13c, 32'h0000071f, 2'h0);
		cmp({24'h0, cmdBlockSkew, cmdBlockTreeDelay}, 32'hff);
		// No commands are in flight here, so a FIFO reset is allowed
		n = fifoResets;
		wr(12'h138, 32'h00000100, 4'h2);
		settle;
		cmp({24'h0, fifoResets}, {24'h0, n + 8'h1});
		rdchk(12'h138, 32'h0000000f, 2'h0);
		wr(12'h138, 32'h00000000, 4'h2);
		settle;
		cmp({24'h0, fifoResets}, {24'h0, n + 8'h1});
		for (int a = 1; a >= 0; a--)
		begin
			n = fifoResets;
			wr(12'h138, 32'(a) << 4, 4'h1);
			@(posedge ref_clk);
			srfReq <= 1'b1;
			repeat (4) @(posedge ref_clk);
			srfReq <= 1'b0;
			settle;
			cmp({24'h0, fifoResets}, {24'h0, n + 8'(a)});
		end
		wr(12'h140, 32'hffffffff, 4'hf);
		rdchk(12'h140, UNMAPPED_DATA, 2'h3);
		rdchk(12'h134, 32'h00000700, 2'h0);
		close_out;
	end
endmodule
`default_nettype wire
